// ===== logic/iwd_decode.sv
`timescale 1ns/1ps
`include "iwd_params.svh"

module iwd_decode #(
    parameter int WORD_W = `IWD_WORD_W
) (
    input wire logic REF_CLK, // core oscillator
    input wire logic NRST, // async reset, active low
    input wire logic [13:0] INSTR_WORD, // fetched word, taken at Q4
    input wire logic TEST_TRUE, // skip test outcome, valid at Q4
    input wire logic PC_WRITTEN, // file write hit the program counter
    input wire logic [7:0] FILE_RDATA, // file read data, valid at Q2
    input wire logic [7:0] ALU_RESULT, // general result, valid at Q3
    output logic [1:0] PHASE, // current oscillator period Q1..Q4
    output logic CYCLE_START, // high during Q1
    output logic [1:0] GROUP, // instruction class
    output logic [5:0] OPCODE, // raw top six bits
    output logic [6:0] FILE_ADDR, // operand register
    output logic DEST_FILE, // result goes to the file register
    output logic [2:0] BIT_SEL, // bit within the register
    output logic [10:0] LITERAL, // constant, zero-extended
    output logic LIT_WIDE, // literal is 11 bits wide
    output logic FILE_RD, // register read strobe in Q2
    output logic FILE_WR, // register write strobe in Q4
    output logic ACC_WR, // accumulator write strobe in Q4
    output logic [7:0] WR_DATA, // value stored at Q4
    output logic FORCED_NOP, // current cycle is the dummy cycle
    output logic PORT_MISMATCH_CLR // port read ends change mismatch
);
    // the field split is wired for one word width only
    if (WORD_W != `IWD_WORD_W)
    begin
        $error("iwd_decode serves only 14-bit words");
    end

    // ==========================================================
    // field split
    iwd_fields_if fld ();
    assign fld.word = INSTR_WORD;

    iwd_field_split u_split (
        .f(fld.split)
    );

    // ==========================================================
    // registers
    iwd_pkg::iwd_phase_e ph_q, ph_d;
    iwd_pkg::iwd_group_e grp_q;
    iwd_pkg::iwd_flags_s flg_q;
    logic [5:0] op_q;
    logic [6:0] addr_q;
    logic dest_q;
    logic [2:0] bsel_q;
    logic [10:0] lit_q;
    logic nop_q, nop_d;
    logic [7:0] rd_q;
    logic [7:0] wr_q, wr_d;

    // bit mask decode, shared by the modify path and its checks
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = 8'h01 << sel;
    endfunction

    wire live = !nop_q;
    wire in_q2 = (ph_q == iwd_pkg::IWD_Q2);
    wire in_q3 = (ph_q == iwd_pkg::IWD_Q3);
    wire in_q4 = (ph_q == iwd_pkg::IWD_Q4);
    wire [7:0] mask = bit_mask(bsel_q);
    wire extra_cycle = live && (flg_q.is_branch || PC_WRITTEN
        || (flg_q.is_skip && TEST_TRUE));

    // four periods per instruction cycle, free running
    always_comb
    begin
        unique case (ph_q)
            iwd_pkg::IWD_Q1: ph_d = iwd_pkg::IWD_Q2;
            iwd_pkg::IWD_Q2: ph_d = iwd_pkg::IWD_Q3;
            iwd_pkg::IWD_Q3: ph_d = iwd_pkg::IWD_Q4;
            iwd_pkg::IWD_Q4: ph_d = iwd_pkg::IWD_Q1;
        endcase
    end

    // modify step; clear to the file and bit ops are done here, the rest by the alu
    assign wr_d = flg_q.is_clear ? 8'h00
        : flg_q.is_bit_clr ? (rd_q & ~mask)
        : flg_q.is_bit_set ? (rd_q | mask) : ALU_RESULT;
    assign nop_d = in_q4 ? extra_cycle : nop_q;

    // phase and dummy-cycle flag
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ph_q <= iwd_pkg::IWD_Q1;
            nop_q <= 1'b1;
        end
        else
        begin
            ph_q <= ph_d;
            nop_q <= nop_d;
        end
    end

    // the next word is latched at the end of Q4, so its fields stand
    // for the whole following cycle
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            grp_q <= iwd_pkg::IWD_GRP_LIT;
            flg_q <= '0;
            op_q <= 6'h00;
            addr_q <= 7'h00;
            dest_q <= 1'b0;
            bsel_q <= 3'h0;
            lit_q <= 11'h000;
        end
        else if (in_q4)
        begin
            grp_q <= fld.grp;
            flg_q <= fld.flags;
            op_q <= fld.opcode;
            addr_q <= fld.addr;
            dest_q <= fld.dest;
            bsel_q <= fld.bsel;
            lit_q <= fld.lit;
        end
    end

    // read data caught at Q2, stored value built at Q3
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rd_q <= 8'h00;
            wr_q <= 8'h00;
        end
        else
        begin
            if (in_q2)
                rd_q <= FILE_RDATA;
            if (in_q3)
                wr_q <= wr_d;
        end
    end

    // ==========================================================
    // outputs; strobes are decoded, data comes from flops
    assign PHASE = ph_q;
    assign CYCLE_START = (ph_q == iwd_pkg::IWD_Q1);
    assign GROUP = grp_q;
    assign OPCODE = op_q;
    assign FILE_ADDR = addr_q;
    assign DEST_FILE = dest_q;
    assign BIT_SEL = bsel_q;
    assign LITERAL = lit_q;
    assign LIT_WIDE = flg_q.lit_wide;
    assign WR_DATA = wr_q;
    assign FORCED_NOP = nop_q;
    // read even for write-only words such as a plain clear or move
    assign FILE_RD = in_q2 && live && flg_q.names_file;
    assign FILE_WR = in_q4 && live && flg_q.writes_file;
    assign ACC_WR = in_q4 && live && flg_q.writes_acc;
    // any port read ends the mismatch, so clearing the port does too
    assign PORT_MISMATCH_CLR = FILE_RD
        && (addr_q == `IWD_PORT_ADDR);

    // ==========================================================
    // checks
    phase_order_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CYCLE_START |=> PHASE == 2'd1 ##1 PHASE == 2'd2 ##1 PHASE == 2'd3
        ##1 CYCLE_START)
        else $error("phase sequence broken");

    read_first_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FILE_WR |-> $past(FILE_RD, 2))
        else $error("file write without prior read");

    clear_zero_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FILE_WR && flg_q.is_clear |-> WR_DATA == 8'h00)
        else $error("clear stored nonzero");

    port_clear_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FILE_WR && flg_q.is_clear && FILE_ADDR == `IWD_PORT_ADDR
        |-> $past(PORT_MISMATCH_CLR, 2))
        else $error("port clear missed mismatch clear");

    bit_set_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FILE_WR && flg_q.is_bit_set
        |-> WR_DATA == ($past(FILE_RDATA, 2) | bit_mask(BIT_SEL)))
        else $error("bit set wrong value");

    bit_clr_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FILE_WR && flg_q.is_bit_clr
        |-> WR_DATA == ($past(FILE_RDATA, 2) & ~bit_mask(BIT_SEL)))
        else $error("bit clear wrong value");

    dest_pick_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        PHASE == 2'd3 && !FORCED_NOP && GROUP == 2'd0
        |-> FILE_WR == DEST_FILE && ACC_WR == !DEST_FILE)
        else $error("destination select ignored");

    two_cycle_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        PHASE == 2'd3 && !FORCED_NOP && flg_q.is_branch
        |=> FORCED_NOP [*4] ##1 !FORCED_NOP)
        else $error("branch not followed by one dummy cycle");

    one_cycle_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        PHASE == 2'd3 && !flg_q.is_branch && !PC_WRITTEN
        && !(flg_q.is_skip && TEST_TRUE) |=> !FORCED_NOP)
        else $error("spurious dummy cycle");

    nop_quiet_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        FORCED_NOP |-> !FILE_RD && !FILE_WR && !ACC_WR)
        else $error("dummy cycle touched state");

    word_class_a: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        GROUP != 2'd3 && (GROUP == 2'd2 || LITERAL[10:8] == 3'h0
        || LIT_WIDE))
        else $error("bad class or literal width");
endmodule

// ===== logic/iwd_field_split.sv
`timescale 1ns/1ps
`include "iwd_params.svh"

module iwd_field_split (
    iwd_fields_if.split f // raw word in, fields out
);
    wire [13:0] w = f.word;
    wire [5:0] op6 = w[`IWD_OP6_HI:`IWD_OP6_LO];
    wire d = w[`IWD_DEST_BIT];
    // top two bits pick the class; the all-zero slot with d low holds
    // the control words, so it counts as literal and control
    wire top_byte = (w[13:12] == 2'b00);
    wire ctrl = top_byte && (op6 == `IWD_OP_STORE_ACC) && !d;
    wire g_byte = top_byte && !ctrl;
    wire g_bit = (w[13:12] == 2'b01);
    wire g_lit = !g_byte && !g_bit;

    // ==========================================================
    // field extraction; don't-care bits are simply never looked at
    assign f.opcode = op6;
    assign f.addr = w[`IWD_ADDR_HI:0];
    assign f.dest = g_byte && d;
    assign f.bsel = w[`IWD_BSEL_HI:`IWD_BSEL_LO];
    assign f.lit = (w[13:12] == 2'b10) ? w[`IWD_LIT11_HI:0]
        : {3'h0, w[`IWD_LIT8_HI:0]};
    assign f.grp = g_byte ? iwd_pkg::IWD_GRP_BYTE
        : g_bit ? iwd_pkg::IWD_GRP_BIT : iwd_pkg::IWD_GRP_LIT;

    // ==========================================================
    // control facts
    assign f.flags.names_file = g_byte || g_bit;
    assign f.flags.writes_file = (g_byte && d) || (g_bit && !w[11]);
    assign f.flags.writes_acc = (g_byte && !d)
        || (w[13:12] == 2'b11);
    assign f.flags.is_clear = g_byte && d && (op6 == `IWD_OP_CLEAR);
    assign f.flags.is_bit_set = g_bit && (w[11:10] == 2'b01);
    assign f.flags.is_bit_clr = g_bit && (w[11:10] == 2'b00);
    assign f.flags.is_skip = (g_byte && (op6 == `IWD_OP_DEC_SKIP
        || op6 == `IWD_OP_INC_SKIP)) || (g_bit && w[11]);
    assign f.flags.is_branch = (w[13:12] == 2'b10)
        || (w[13:1] == `IWD_RET_PAIR)
        || (w[13:10] == `IWD_RET_LIT_TOP);
    assign f.flags.lit_wide = (w[13:12] == 2'b10);
endmodule

// ===== logic/iwd_fields_if.sv
`timescale 1ns/1ps
`include "iwd_params.svh"

// carries one raw word and its decoded fields
interface iwd_fields_if;
    logic [`IWD_WORD_W-1:0] word;
    iwd_pkg::iwd_group_e grp;
    iwd_pkg::iwd_flags_s flags;
    logic [5:0] opcode;
    logic [6:0] addr;
    logic dest;
    logic [2:0] bsel;
    logic [10:0] lit;

    modport split (input word, output grp, flags, opcode, addr, dest, bsel,
        lit);
    modport core (output word, input grp, flags, opcode, addr, dest, bsel,
        lit);
endinterface

// ===== logic/iwd_params.svh
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH

// ==========================================================
// word format
`define IWD_WORD_W 14
`define IWD_OP6_HI 13
`define IWD_OP6_LO 8
`define IWD_DEST_BIT 7
`define IWD_ADDR_HI 6
`define IWD_BSEL_HI 9
`define IWD_BSEL_LO 7
`define IWD_LIT8_HI 7
`define IWD_LIT11_HI 10

// ==========================================================
// opcode values and addresses
`define IWD_OP_STORE_ACC 6'h00
`define IWD_OP_CLEAR 6'h01
`define IWD_OP_DEC_SKIP 6'h0b
`define IWD_OP_INC_SKIP 6'h0f
`define IWD_RET_PAIR 13'h0004
`define IWD_RET_LIT_TOP 4'hd
`define IWD_PORT_ADDR 7'h05
`define IWD_FILE_TOP 7'h7f

// ==========================================================
// timing
`define IWD_OSC_PER_CYCLE 4
`define IWD_CLK_PERIOD_NS 10

`endif

// ===== logic/iwd_pkg.sv
package iwd_pkg;

    // instruction class
    typedef enum logic [1:0] {IWD_GRP_BYTE, IWD_GRP_BIT, IWD_GRP_LIT} iwd_group_e;

    // oscillator period inside one instruction cycle
    typedef enum logic [1:0] {IWD_Q1, IWD_Q2, IWD_Q3, IWD_Q4} iwd_phase_e;

    // per-word control facts
    typedef struct packed {
        logic names_file;
        logic writes_file;
        logic writes_acc;
        logic is_clear;
        logic is_bit_set;
        logic is_bit_clr;
        logic is_skip;
        logic is_branch;
        logic lit_wide;
    } iwd_flags_s;

endpackage

// ===== testbench/tb_instruction_word_decode.sv
`timescale 1ns/1ps
`include "iwd_params.svh"

module tb_instruction_word_decode;
    logic ref_clk;
    logic nrst;
    logic [13:0] instr_word;
    logic test_true;
    logic pc_written;
    logic [7:0] file_rdata;
    logic [7:0] alu_result;
    logic [1:0] phase;
    logic cycle_start;
    logic [1:0] group;
    logic [5:0] opcode;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_sel;
    logic [10:0] literal;
    logic lit_wide;
    logic file_rd;
    logic file_wr;
    logic acc_wr;
    logic [7:0] wr_data;
    logic forced_nop;
    logic port_mismatch_clr;
    int mismatches;
    int compares;

    iwd_decode u_dut (.REF_CLK(ref_clk), .NRST(nrst), .INSTR_WORD(instr_word),
        .TEST_TRUE(test_true), .PC_WRITTEN(pc_written),
        .FILE_RDATA(file_rdata), .ALU_RESULT(alu_result), .PHASE(phase),
        .CYCLE_START(cycle_start), .GROUP(group), .OPCODE(opcode),
        .FILE_ADDR(file_addr), .DEST_FILE(dest_file), .BIT_SEL(bit_sel),
        .LITERAL(literal), .LIT_WIDE(lit_wide), .FILE_RD(file_rd),
        .FILE_WR(file_wr), .ACC_WR(acc_wr), .WR_DATA(wr_data),
        .FORCED_NOP(forced_nop), .PORT_MISMATCH_CLR(port_mismatch_clr));

    // ==========================================================
    // compare and report
    task automatic chk_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_vec(input string what, input logic [10:0] e,
        input logic [10:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // bounded wait, so a stuck phase counter cannot hang the run
    task automatic wait_phase(input logic [1:0] p);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (phase !== p && n < 8)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (phase !== p)
        begin
            mismatches++;
            print_verdict();
        end
    endtask

    // ==========================================================
    // one word through a full instruction cycle plus the next Q1
    task automatic run(input logic [13:0] w, input logic [7:0] rd,
        input logic [7:0] alu, input logic tt, input logic pcw);
        logic by;
        logic bi;
        logic wide;
        logic fwr;
        logic awr;
        logic two;
        logic [7:0] m;
        logic [7:0] wd;
        m = 8'h01 << w[9:7];
        bi = w[13:12] == 2'b01;
        by = w[13:12] == 2'b00 && !(w[11:8] == 4'h0 && !w[7]);
        wide = w[13:12] == 2'b10;
        fwr = (by && w[7]) || (bi && !w[11]);
        awr = (by && !w[7]) || w[13:12] == 2'b11;
        // only the clear to the file is built inside; to the accumulator
        // the value comes from the alu like any other byte operation
        wd = (by && w[7] && w[13:8] == `IWD_OP_CLEAR) ? 8'h00 : alu;
        if (bi && !w[11])
            wd = w[10] ? (rd | m) : (rd & ~m);
        two = wide || w[13:10] == `IWD_RET_LIT_TOP || w[13:1] == `IWD_RET_PAIR;
        two = two || pcw || (tt && (w[13:8] == `IWD_OP_DEC_SKIP
            || w[13:8] == `IWD_OP_INC_SKIP || w[13:11] == 3'b011));
        wait_phase(2'h2);
        @(posedge ref_clk);
        instr_word <= w;
        @(posedge ref_clk);
        instr_word <= 14'h0000;
        file_rdata <= rd;
        alu_result <= alu;
        test_true <= tt;
        pc_written <= pcw;
        @(negedge ref_clk);
        chk_bit("cycle_start", 1'b1, cycle_start);
        chk_bit("forced_nop", 1'b0, forced_nop);
        chk_vec("group", {9'h0, by ? 2'h0 : bi ? 2'h1 : 2'h2},
            {9'h0, group});
        chk_vec("opcode", {5'h0, w[13:8]}, {5'h0, opcode});
        chk_vec("file_addr", {4'h0, w[6:0]}, {4'h0, file_addr});
        chk_bit("dest_file", by & w[7], dest_file);
        chk_vec("bit_sel", {8'h0, w[9:7]}, {8'h0, bit_sel});
        chk_vec("literal", wide ? w[10:0] : {3'h0, w[7:0]}, literal);
        chk_bit("lit_wide", wide, lit_wide);
        @(negedge ref_clk);
        chk_bit("file_rd", by | bi, file_rd);
        chk_bit("port_clr", (by | bi) && w[6:0] == `IWD_PORT_ADDR,
            port_mismatch_clr);
        repeat (2) @(negedge ref_clk);
        chk_bit("file_wr", fwr, file_wr);
        chk_bit("acc_wr", awr, acc_wr);
        if (fwr || awr)
            chk_vec("wr_data", {3'h0, wd}, {3'h0, wr_data});
        @(posedge ref_clk);
        test_true <= 1'b0;
        pc_written <= 1'b0;
        @(negedge ref_clk);
        chk_bit("dummy_cycle", two, forced_nop);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        @(posedge ref_clk);
        nrst <= 1'b0;
        @(negedge ref_clk);
        chk_vec("rst_phase", 11'h000, {9'h0, phase});
        chk_bit("rst_nop", 1'b1, forced_nop);
        chk_vec("rst_group", 11'h002, {9'h0, group});
        @(posedge ref_clk);
        nrst <= 1'b1;
        wait_phase(2'h3);
        chk_bit("first_dummy", 1'b1, forced_nop);
    endtask

    task automatic t_byte;
        for (int i = 0; i < 4; i++)
            run({6'h07, i[0], i[1] ? 7'h7f : 7'h00}, 8'h3c, 8'h5a,
                1'b0, 1'b0);
        run(14'h0785, 8'h11, 8'h22, 1'b0, 1'b0);
    endtask

    task automatic t_clear;
        run(14'h0185, 8'hff, 8'h77, 1'b0, 1'b0);
        run(14'h0100, 8'hff, 8'h77, 1'b0, 1'b0);
        run(14'h00ff, 8'h12, 8'h34, 1'b0, 1'b0);
    endtask

    task automatic t_bits;
        for (int b = 0; b < 8; b++)
        begin
            run(14'h1005 | (b[2:0] << 7), 8'ha5, 8'h00, 1'b0, 1'b0);
            run(14'h1405 | (b[2:0] << 7), 8'ha5, 8'h00, 1'b0, 1'b0);
        end
    endtask

    // don't-care bits set and clear must decode alike
    task automatic t_literal;
        run(14'h303c, 8'h00, 8'h3c, 1'b0, 1'b0);
        run(14'h333c, 8'h00, 8'h3c, 1'b0, 1'b0);
        run(14'h3e0f, 8'h00, 8'h9e, 1'b0, 1'b0);
        run(14'h2fff, 8'h00, 8'h00, 1'b0, 1'b0);
        run(14'h2555, 8'h00, 8'h00, 1'b0, 1'b0);
        run(14'h3455, 8'h00, 8'h55, 1'b0, 1'b0);
        run(14'h0008, 8'h00, 8'h00, 1'b0, 1'b0);
        run(14'h0009, 8'h00, 8'h00, 1'b0, 1'b0);
        run(14'h0000, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_skip;
        run(14'h0b85, 8'h01, 8'h00, 1'b0, 1'b0);
        run(14'h0b85, 8'h01, 8'h00, 1'b1, 1'b0);
        run(14'h0f05, 8'hff, 8'h00, 1'b1, 1'b0);
        run(14'h1805, 8'h00, 8'h00, 1'b1, 1'b0);
        run(14'h1c85, 8'h00, 8'h00, 1'b0, 1'b0);
        run(14'h0782, 8'h10, 8'h20, 1'b0, 1'b1);
    endtask

    // ==========================================================
    // clock, reset and main sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        mismatches = 0;
        compares = 0;
        nrst = 1'b0;
        instr_word = 14'h0000;
        test_true = 1'b0;
        pc_written = 1'b0;
        file_rdata = 8'h00;
        alu_result = 8'h00;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_byte();
        t_clear();
        t_bits();
        t_reset();
        t_literal();
        t_skip();
        print_verdict();
    end
endmodule
